// [rtl/adc_bus_master.sv]
// bus master end: turns user commands into safe register access sequences
`timescale 1ns/1ps
`default_nettype none
module adc_bus_master (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // peripheral bus
    adc_bus_if.host          bus,
    // user command port
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic        cmd_dma,
    input  wire logic [4:0]  cmd_addr,
    input  wire logic [7:0]  cmd_wdata,
    output logic             cmd_ready,
    output logic             resp_valid,
    output logic [15:0]      resp_data,
    output logic             irq
);
    import adc_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_CSR_RD,
        ST_CSR_WAIT,
        ST_STOP_WR,
        ST_FINAL_WR,
        ST_HI_RD,
        ST_HI_WAIT,
        ST_LO_RD,
        ST_LO_WAIT
    } hst_state_t;

    typedef struct packed {
        hst_state_t  st;
        logic [4:0]  addr;
        logic [7:0]  wdata;
        logic        dma;
        logic [7:0]  hi;
        logic [4:0]  b_addr;
        logic        b_rd;
        logic        b_wr;
        logic [7:0]  b_wdata;
        logic        b_dma;
        logic        ready;
        logic        rvalid;
        logic [15:0] rdata;
        logic        irq;
    } hst_t;

    hst_t cur_ff;
    hst_t nxt_cur;

    // ************************************************************
    // command sequencer
    // ************************************************************
    always_comb begin
        nxt_cur        = cur_ff;
        nxt_cur.b_rd   = 1'b0;
        nxt_cur.b_wr   = 1'b0;
        nxt_cur.rvalid = 1'b0;
        nxt_cur.irq    = bus.done_irq;
        case (cur_ff.st)
            ST_IDLE: begin
                if (cmd_valid) begin
                    nxt_cur.ready = 1'b0;
                    nxt_cur.addr  = cmd_addr;
                    nxt_cur.dma   = cmd_dma;
                    nxt_cur.wdata = cmd_wdata;
                    if (cmd_write && cmd_addr == OFS_CTRL)
                        nxt_cur.wdata = (cmd_wdata & CTRL_WMASK) | CTRL_FIXED;  // [RULE_19]
                    if (cmd_write)
                        nxt_cur.st = ST_CSR_RD;  // [RULE_02]
                    else if (is_result(cmd_addr))
                        nxt_cur.st = ST_HI_RD;  // [RULE_21]
                    else
                        nxt_cur.st = ST_LO_RD;
                end
            end
            ST_CSR_RD: begin
                nxt_cur.b_rd   = 1'b1;
                nxt_cur.b_addr = OFS_CSR;
                nxt_cur.b_dma  = 1'b0;
                nxt_cur.st     = ST_CSR_WAIT;
            end
            ST_CSR_WAIT: begin
                if (bus.bus_rvalid) begin
                    nxt_cur.hi = bus.bus_rdata[15:8];
                    // running and a setting would change: stop first
                    if (bus.bus_rdata[8+CSR_GO] &&
                        (cur_ff.addr == OFS_CTRL ||
                         (cur_ff.addr == OFS_CSR &&
                          (cur_ff.wdata[CSR_IRQEN] != bus.bus_rdata[8+CSR_IRQEN] ||
                           cur_ff.wdata[4:0] != bus.bus_rdata[12:8]))))
                        nxt_cur.st = ST_STOP_WR;  // [RULE_05] [RULE_12] [RULE_14] [RULE_18]
                    else
                        nxt_cur.st = ST_FINAL_WR;
                end
            end
            ST_STOP_WR: begin
                nxt_cur.b_wr    = 1'b1;
                nxt_cur.b_addr  = OFS_CSR;
                // flag bit written as one so the stop cannot clear it
                nxt_cur.b_wdata = cur_ff.hi & ~(8'h01 << CSR_GO) | 8'h80;  // [RULE_12] [RULE_14]
                nxt_cur.st      = ST_FINAL_WR;
            end
            ST_FINAL_WR: begin
                nxt_cur.b_wr    = 1'b1;
                nxt_cur.b_addr  = cur_ff.addr;
                nxt_cur.b_wdata = cur_ff.wdata;
                nxt_cur.ready   = 1'b1;
                nxt_cur.st      = ST_IDLE;
            end
            ST_HI_RD: begin
                nxt_cur.b_rd   = 1'b1;
                nxt_cur.b_addr = {cur_ff.addr[4:2], 2'b00};  // [RULE_21]
                nxt_cur.b_dma  = cur_ff.dma;
                nxt_cur.st     = ST_HI_WAIT;
            end
            ST_HI_WAIT: begin
                if (bus.bus_rvalid) begin
                    nxt_cur.hi   = bus.bus_rdata[15:8];
                    nxt_cur.addr = {cur_ff.addr[4:2], 2'b10};
                    nxt_cur.st   = ST_LO_RD;
                end
            end
            ST_LO_RD: begin
                nxt_cur.b_rd   = 1'b1;
                nxt_cur.b_addr = cur_ff.addr;
                nxt_cur.b_dma  = cur_ff.dma;
                nxt_cur.st     = ST_LO_WAIT;
            end
            ST_LO_WAIT: begin
                if (bus.bus_rvalid) begin
                    nxt_cur.rvalid = 1'b1;
                    nxt_cur.rdata  = is_result(cur_ff.addr)
                                   ? {cur_ff.hi, bus.bus_rdata[15:8]}
                                   : {8'h00, bus.bus_rdata[15:8]};
                    nxt_cur.ready  = 1'b1;
                    nxt_cur.st     = ST_IDLE;
                end
            end
            default: begin
                nxt_cur.st    = ST_IDLE;
                nxt_cur.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cur_ff       <= '0;
            cur_ff.st    <= ST_IDLE;
            cur_ff.ready <= 1'b1;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // outputs straight from flops
    assign bus.bus_addr  = cur_ff.b_addr;
    assign bus.bus_rd    = cur_ff.b_rd;
    assign bus.bus_wr    = cur_ff.b_wr;
    assign bus.bus_wdata = cur_ff.b_wdata;
    assign bus.bus_dma   = cur_ff.b_dma;
    assign cmd_ready     = cur_ff.ready;
    assign resp_valid    = cur_ff.rvalid;
    assign resp_data     = cur_ff.rdata;
    assign irq           = cur_ff.irq;
endmodule
`default_nettype wire

// [rtl/adc_pkg.sv]
// shared constants, types and decode helpers for the converter control block
// ****************************************************************
// Notes on behaviour
// RULE_01: done flag sets when selected conversions end
// RULE_02: flag clears by read-at-one then write zero
// RULE_03: transfer-engine result read also clears flag
// RULE_04: interrupt requested only while enable bit set
// RULE_05: software changes interrupt enable only when idle
// RULE_06: go bit held high through conversion; soft/trigger
// RULE_07: single mode: one conversion, go auto-clears
// RULE_08: multi mode: channels in order, go auto-clears
// RULE_09: scan repeats until go cleared, reset, standby
// RULE_10: mode decode: 00 single, 10 multi, 11 scan
// RULE_11: slow speed 536 states, fast 266 states
// RULE_12: software stops conversion before changing speed
// RULE_13: channel code picks input or group plus count
// RULE_14: software stops conversion before changing channels
// RULE_15: status register resets to 00 incl. standby
// RULE_16: control register resets to 07 incl. standby
// RULE_17: trigger high bit enables falling-edge start
// RULE_18: software changes trigger enables only when idle
// RULE_19: control bits 4,3 read 0; 2..0 read 1
// RULE_20: upper-byte read latches lower byte into holding
// RULE_21: master reads upper byte before lower byte
// RULE_22: result 9..2 upper, 1..0 lower bits 7..6
// RULE_23: inputs n and n+4 share result register n
// RULE_24: writing one to flag does nothing; irq level
// ****************************************************************
package adc_pkg;
    // ************************************************************
    // bus map, byte offsets within the block
    // ************************************************************
    localparam int          ADDR_W      = 5;
    localparam logic [4:0]  OFS_RES_A_HI = 5'h00;  // results A..D at 0x00..0x0E
    localparam logic [4:0]  OFS_RES_END = 5'h0F;
    localparam logic [4:0]  OFS_CSR     = 5'h10;
    localparam logic [4:0]  OFS_CTRL    = 5'h12;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int          CSR_FLAG    = 7;
    localparam int          CSR_IRQEN   = 6;
    localparam int          CSR_GO      = 5;
    localparam int          CSR_MULTI   = 4;
    localparam int          CSR_SPEED   = 3;
    localparam int          CTRL_TRG_HI = 7;
    localparam int          CTRL_TRG_LO = 6;
    localparam int          CTRL_SCAN   = 5;
    localparam logic [7:0]  CSR_RST     = 8'h00;
    localparam logic [7:0]  CTRL_RST    = 8'h07;
    localparam logic [7:0]  CTRL_FIXED  = 8'h07;  // bits 2..0 read one, 4..3 zero
    localparam logic [7:0]  CTRL_WMASK  = 8'hE0;
    localparam int          RES_W       = 10;

    // ************************************************************
    // timing: one converter state is one ref_clk period
    // ************************************************************
    localparam int          CLK_HZ      = 20000000;
    localparam int          CONV_SLOW   = 536;    // states, longest time
    localparam int          CONV_FAST   = 266;
    localparam int          CNT_W       = 10;
    localparam logic [9:0]  CONV_SLOW_CYC = 10'(CONV_SLOW - 1);
    localparam logic [9:0]  CONV_FAST_CYC = 10'(CONV_FAST - 1);

    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_MULTI,
        MODE_SCAN
    } conv_mode_t;

    // result register window
    function automatic logic is_result(input logic [4:0] a);
        return a <= OFS_RES_END;
    endfunction

    // mode from multi and scan selects; 0/1 treated as single
    function automatic conv_mode_t mode_of(input logic multi, input logic scan);
        if (!multi)
            return MODE_SINGLE;
        return scan ? MODE_SCAN : MODE_MULTI;
    endfunction
endpackage

// [rtl/adc_bus_if.sv]
// peripheral bus between the bus master end and the converter end
`timescale 1ns/1ps
`default_nettype none
interface adc_bus_if;
    logic [4:0]  bus_addr;     // byte offset
    logic        bus_rd;       // read strobe, one cycle
    logic        bus_wr;       // write strobe, one cycle
    logic [7:0]  bus_wdata;
    logic        bus_dma;      // current read issued by transfer engine
    logic [15:0] bus_rdata;    // byte on upper 8 bits
    logic        bus_rvalid;   // one cycle after bus_rd
    logic        done_irq;     // level interrupt request

    modport device (input bus_addr, bus_rd, bus_wr, bus_wdata, bus_dma,
                    output bus_rdata, bus_rvalid, done_irq);
    modport host   (output bus_addr, bus_rd, bus_wr, bus_wdata, bus_dma,
                    input bus_rdata, bus_rvalid, done_irq);
endinterface
`default_nettype wire

// [rtl/adc_conv_timer.sv]
// conversion time counter, pulses once per finished channel
`timescale 1ns/1ps
`default_nettype none
module adc_conv_timer (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic resetn,
    // control
    input  wire logic run,
    input  wire logic fast,
    // status
    output logic      chan_done
);
    import adc_pkg::*;

    typedef struct packed {
        logic [9:0] cnt;
        logic       done;
    } tmr_t;

    tmr_t cur_ff;
    tmr_t nxt_cur;

    // count while running, restart from zero each channel
    always_comb begin
        nxt_cur      = cur_ff;
        nxt_cur.done = 1'b0;
        if (!run) begin
            nxt_cur.cnt = '0;
        end else if (cur_ff.cnt == (fast ? CONV_FAST_CYC : CONV_SLOW_CYC)) begin  // [RULE_11]
            nxt_cur.cnt  = '0;
            nxt_cur.done = 1'b1;
        end else begin
            nxt_cur.cnt = cur_ff.cnt + 10'h001;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            cur_ff <= '0;
        else
            cur_ff <= nxt_cur;
    end

    assign chan_done = cur_ff.done;
endmodule
`default_nettype wire

// [rtl/adc_converter.sv]
// converter end: status/control registers, sequencer, result read path
`timescale 1ns/1ps
`default_nettype none
module adc_converter (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    // peripheral bus
    adc_bus_if.device       bus,
    // power and pins
    input  wire logic       standby,
    input  wire logic       ext_trigger_pin,
    // sampled value of the selected input
    input  wire logic [9:0] sample_value,
    output logic [2:0]      sample_channel
);
    import adc_pkg::*;

    typedef struct packed {
        logic [7:0]  csr;        // flag, irq enable, go, multi, speed, code
        logic [2:0]  trg;        // trigger hi, trigger lo, scan
        logic        armed;      // flag seen at one by a read
        logic [39:0] res;        // four 10-bit results, A in low bits
        logic [7:0]  hold;       // lower byte holding
        logic [1:0]  idx;        // channel within group
        logic [2:0]  trg_sync;
        logic        trg_lvl;    // debounced pin level
        logic [15:0] rdata;
        logic        rvalid;
        logic        irq;
        logic [2:0]  chan;
    } dev_t;

    dev_t       cur_ff;
    dev_t       nxt_cur;
    logic       chan_done;
    conv_mode_t mode;
    logic [1:0] ridx;
    logic [1:0] slot;
    logic       trg_fall;
    logic       last;

    // ************************************************************
    // conversion time
    // ************************************************************
    adc_conv_timer u_timer (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .run       (cur_ff.csr[CSR_GO]),
        .fast      (cur_ff.csr[CSR_SPEED]),
        .chan_done (chan_done)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        nxt_cur        = cur_ff;
        nxt_cur.rvalid = 1'b0;
        mode     = mode_of(cur_ff.csr[CSR_MULTI], cur_ff.trg[0]);  // [RULE_10]
        ridx     = bus.bus_addr[3:2];
        // result slot: single uses code, groups use running index
        slot     = (mode == MODE_SINGLE) ? cur_ff.csr[1:0] : cur_ff.idx;  // [RULE_23]
        last     = (mode == MODE_SINGLE) || (cur_ff.idx == cur_ff.csr[1:0]);  // [RULE_13]
        trg_fall = 1'b0;

        // pin synchroniser, level accepted when stages two and three agree
        nxt_cur.trg_sync = {cur_ff.trg_sync[1:0], ext_trigger_pin};
        if (cur_ff.trg_sync[1] == cur_ff.trg_sync[2]) begin
            nxt_cur.trg_lvl = cur_ff.trg_sync[2];
            trg_fall = cur_ff.trg_lvl && !cur_ff.trg_sync[2];
        end

        // bus reads
        if (bus.bus_rd) begin
            nxt_cur.rvalid = 1'b1;
            nxt_cur.rdata  = 16'h0000;
            if (is_result(bus.bus_addr)) begin
                if (!bus.bus_addr[1]) begin
                    // upper byte direct, lower byte into holding
                    nxt_cur.rdata[15:8] = cur_ff.res[ridx*RES_W+2 +: 8];  // [RULE_22] [RULE_20]
                    nxt_cur.hold = {cur_ff.res[ridx*RES_W +: 2], 6'h00};  // [RULE_22] [RULE_20]
                end else begin
                    nxt_cur.rdata[15:8] = cur_ff.hold;  // [RULE_20]
                end
                if (bus.bus_dma)
                    nxt_cur.csr[CSR_FLAG] = 1'b0;  // [RULE_03]
            end else if (bus.bus_addr == OFS_CSR) begin
                nxt_cur.rdata[15:8] = cur_ff.csr;
                if (cur_ff.csr[CSR_FLAG])
                    nxt_cur.armed = 1'b1;  // [RULE_02]
            end else if (bus.bus_addr == OFS_CTRL) begin
                nxt_cur.rdata[15:8] = {cur_ff.trg, 5'h00} | CTRL_FIXED;  // [RULE_19]
            end
        end

        // bus writes; spare bits a/b and the fixed ones are not stored
        if (bus.bus_wr) begin
            if (bus.bus_addr == OFS_CSR) begin
                nxt_cur.csr[6:0] = bus.bus_wdata[6:0];  // [RULE_06]
                if (!bus.bus_wdata[CSR_FLAG] && cur_ff.armed) begin
                    nxt_cur.csr[CSR_FLAG] = 1'b0;  // [RULE_02] [RULE_24]
                    nxt_cur.armed = 1'b0;
                end
                // fresh start or restart begins at the group head
                if (bus.bus_wdata[CSR_GO] && !cur_ff.csr[CSR_GO])
                    nxt_cur.idx = 2'b00;
            end else if (bus.bus_addr == OFS_CTRL) begin
                nxt_cur.trg = bus.bus_wdata[7:5];  // [RULE_17]
            end
        end

        // accepted external trigger starts a conversion
        if (trg_fall && cur_ff.trg[2] && !cur_ff.csr[CSR_GO]) begin  // [RULE_17]
            nxt_cur.csr[CSR_GO] = 1'b1;  // [RULE_06]
            nxt_cur.idx = 2'b00;
        end

        // end of one channel; a software stop in this cycle wins
        if (chan_done && cur_ff.csr[CSR_GO] && nxt_cur.csr[CSR_GO]) begin
            nxt_cur.res[slot*RES_W +: RES_W] = sample_value;  // [RULE_23]
            if (last) begin
                nxt_cur.csr[CSR_FLAG] = 1'b1;  // [RULE_01]
                nxt_cur.idx = 2'b00;
                if (mode != MODE_SCAN)
                    nxt_cur.csr[CSR_GO] = 1'b0;  // [RULE_07] [RULE_08] [RULE_09]
            end else begin
                nxt_cur.idx = cur_ff.idx + 2'b01;  // [RULE_08]
            end
        end

        // input presented to the sampler
        nxt_cur.chan = (mode == MODE_SINGLE) ? cur_ff.csr[2:0]
                                             : {cur_ff.csr[2], nxt_cur.idx};  // [RULE_13]
        if (!nxt_cur.csr[CSR_FLAG])
            nxt_cur.armed = 1'b0;

        // level request while flag and enable are both one
        nxt_cur.irq = nxt_cur.csr[CSR_FLAG] && nxt_cur.csr[CSR_IRQEN];  // [RULE_04] [RULE_24]

        // standby returns registers to their reset values
        if (standby) begin
            nxt_cur.csr   = CSR_RST;  // [RULE_15] [RULE_09]
            nxt_cur.trg   = CTRL_RST[7:5];  // [RULE_16]
            nxt_cur.res   = '0;
            nxt_cur.hold  = 8'h00;
            nxt_cur.idx   = 2'b00;
            nxt_cur.armed = 1'b0;
            nxt_cur.irq   = 1'b0;
            nxt_cur.chan  = 3'h0;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cur_ff          <= '0;
            cur_ff.csr      <= CSR_RST;  // [RULE_15]
            cur_ff.trg      <= CTRL_RST[7:5];  // [RULE_16]
            cur_ff.trg_sync <= 3'h7;
            cur_ff.trg_lvl  <= 1'b1;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // outputs straight from flops
    assign bus.bus_rdata  = cur_ff.rdata;
    assign bus.bus_rvalid = cur_ff.rvalid;
    assign bus.done_irq   = cur_ff.irq;
    assign sample_channel = cur_ff.chan;
endmodule
`default_nettype wire

// [bench/adc_bus_assertions.sv]
// concurrent checks on the bus joining the two ends
`timescale 1ns/1ps
`default_nettype none
module adc_bus_assertions
    import adc_pkg::*;
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        resetn,
    // host side of the bus
    input wire logic [4:0]  bus_addr,
    input wire logic        bus_rd,
    input wire logic        bus_wr,
    input wire logic [7:0]  bus_wdata,
    input wire logic        bus_dma,
    // device side of the bus
    input wire logic [15:0] bus_rdata,
    input wire logic        bus_rvalid,
    input wire logic        done_irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // ************************************************************
    // flag clear steps
    // ************************************************************
    sequence s_armed;
        bus_rd && bus_addr == OFS_CSR ##1 bus_rdata[15];
    endsequence
    sequence s_clear;
        bus_wr && bus_addr == OFS_CSR && !bus_wdata[7];
    endsequence
    sequence s_csr_rd;
        bus_rd && bus_addr == OFS_CSR;
    endsequence
    rvalid_after_rd_a: assert property (bus_rd |=> bus_rvalid)
        else $error("read not answered");
    rvalid_only_a: assert property (!bus_rd |=> !bus_rvalid)
        else $error("answer without read");
    low_lane_zero_a: assert property (bus_rd |=> bus_rdata[7:0] == 8'h00)
        else $error("low lane not zero");
    ctrl_fixed_a: assert property (bus_rd && bus_addr == OFS_CTRL
        |=> bus_rdata[12:0] == 13'h0700) else $error("control fixed bits wrong");
    lo_byte_zero_a: assert property (bus_rd && bus_addr <= OFS_RES_END && bus_addr[1]
        |=> bus_rdata[13:8] == 6'h00) else $error("result low bits not zero");
    irq_flag_on_a: assert property (s_csr_rd and done_irq
        |=> bus_rdata[15:14] == 2'b11) else $error("irq without flag and enable");
    irq_flag_off_a: assert property (s_csr_rd and !done_irq
        |=> bus_rdata[15:14] != 2'b11) else $error("flag and enable without irq");
    flag_clear_a: assert property (s_armed ##[1:8] s_clear |-> ##2 !done_irq)
        else $error("armed zero write did not clear");
    write_one_a: assert property (done_irq && bus_wr && bus_addr == OFS_CSR
        && bus_wdata[7:6] == 2'b11 |=> done_irq) else $error("write of one cleared flag");
    dma_clear_a: assert property (bus_rd && bus_dma && bus_addr <= OFS_RES_END
        |-> ##2 !done_irq) else $error("engine read did not clear");
    unmapped_a: assert property (bus_rd && bus_addr > 5'h13
        |=> bus_rdata == 16'h0000) else $error("unmapped read not zero");
endmodule
`default_nettype wire

// [bench/tb_adc_sequencer_control.sv]
// testbench joining bus master and converter ends
`timescale 1ns/1ps
`default_nettype none
module tb_adc_sequencer_control;
    import adc_pkg::*;
    // clock, reset and converter inputs
    logic        ref_clk         = 1'b0;
    logic        resetn          = 1'b0;
    logic        standby         = 1'b0;
    logic        ext_trigger_pin = 1'b1;
    logic [9:0]  sample_value;
    logic [2:0]  sample_channel;
    // command port
    logic        cmd_valid       = 1'b0;
    logic        cmd_write       = 1'b0;
    logic        cmd_dma         = 1'b0;
    logic [4:0]  cmd_addr        = 5'h00;
    logic [7:0]  cmd_wdata       = 8'h00;
    logic        cmd_ready;
    logic        resp_valid;
    logic [15:0] resp_data;
    logic        irq;
    logic [9:0]  sv [8];
    logic [15:0] exp_q [$];
    int          n_mismatch      = 0;
    int          n_checks        = 0;
    int          seed            = 77202;

    adc_bus_if adc_bus_if_i ();
    adc_converter adc_converter_i (.ref_clk(ref_clk), .resetn(resetn), .bus(adc_bus_if_i),
        .standby(standby), .ext_trigger_pin(ext_trigger_pin),
        .sample_value(sample_value), .sample_channel(sample_channel));
    adc_bus_master adc_bus_master_i (.ref_clk(ref_clk), .resetn(resetn), .bus(adc_bus_if_i),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_dma(cmd_dma), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
        .resp_data(resp_data), .irq(irq));
    adc_bus_assertions adc_bus_assertions_i (.ref_clk(ref_clk), .resetn(resetn),
        .bus_addr(adc_bus_if_i.bus_addr), .bus_rd(adc_bus_if_i.bus_rd),
        .bus_wr(adc_bus_if_i.bus_wr), .bus_wdata(adc_bus_if_i.bus_wdata),
        .bus_dma(adc_bus_if_i.bus_dma), .bus_rdata(adc_bus_if_i.bus_rdata),
        .bus_rvalid(adc_bus_if_i.bus_rvalid), .done_irq(adc_bus_if_i.done_irq));

    // analog value seen on the selected input
    assign sample_value = sv[sample_channel];

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    function automatic logic [15:0] res(input logic [9:0] v);
        return {v, 6'h00};
    endfunction
    // one command, held for one rising edge, then wait up to 20 cycles for idle
    task automatic cmd(input logic w, input logic d, input logic [4:0] a, input logic [7:0] v);
        int i;
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_dma   = d;
        cmd_addr  = a;
        cmd_wdata = v;
        @(posedge ref_clk);
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        for (i = 0; i < 20 && cmd_ready !== 1'b1; i++) @(negedge ref_clk);
    endtask
    task automatic rd(input logic [4:0] a, input logic d, input logic [15:0] e);
        exp_q.push_back(e);
        cmd(1'b0, d, a, 8'h00);
    endtask
    task automatic wait_irq(input int lo, input int hi);
        int i;
        i = 0;
        while (irq !== 1'b1 && i < 1000) begin
            @(negedge ref_clk);
            i++;
        end
        check("irq_time", 16'h0001, {15'h0000, (i >= lo && i <= hi)});
    endtask
    task automatic trig();
        @(negedge ref_clk);
        ext_trigger_pin = 1'b0;
        repeat (8) @(negedge ref_clk);
        ext_trigger_pin = 1'b1;
        repeat (600) @(negedge ref_clk);
    endtask

    // clock and watchdog
    initial forever #25 ref_clk = ~ref_clk;
    initial begin
        repeat (10000) @(posedge ref_clk);
        n_mismatch++;
        results();
    end
    // response monitor, oldest note first; samples mid-cycle once flops settle
    always @(negedge ref_clk) begin
        if (resp_valid === 1'b1 && exp_q.size() > 0)
            check("resp", exp_q.pop_front(), resp_data);
    end

    // main sequence
    initial begin
        for (int i = 0; i < 8; i++) sv[i] = 10'($random(seed));
        repeat (10) @(negedge ref_clk);
        resetn = 1'b1;
        rd(OFS_CSR, 1'b0, 16'h0000);
        rd(OFS_CTRL, 1'b0, 16'h0007);
        rd(5'h18, 1'b0, 16'h0000);
        // single mode, input 5, slow timing, irq on
        cmd(1'b1, 1'b0, OFS_CSR, 8'h65);
        wait_irq(530, 545);
        rd(5'h04, 1'b0, res(sv[5]));
        rd(OFS_CSR, 1'b0, 16'h00C5);
        cmd(1'b1, 1'b0, OFS_CSR, 8'hC5);
        rd(OFS_CSR, 1'b0, 16'h00C5);
        cmd(1'b1, 1'b0, OFS_CSR, 8'h45);
        rd(OFS_CSR, 1'b0, 16'h0045);
        check("irq_clear", 16'h0000, {15'h0000, irq});
        // multi mode, group 1, three inputs, fast, irq off
        cmd(1'b1, 1'b0, OFS_CSR, 8'h3E);
        repeat (900) @(negedge ref_clk);
        check("irq_masked", 16'h0000, {15'h0000, irq});
        rd(OFS_CSR, 1'b0, 16'h009E);
        for (int i = 0; i < 3; i++) rd(5'(4 * i), 1'b0, res(sv[4 + i]));
        rd(5'h0C, 1'b0, 16'h0000);
        rd(5'h00, 1'b1, res(sv[4]));
        rd(OFS_CSR, 1'b0, 16'h001E);
        // scan mode on input 0, started from the pin
        cmd(1'b1, 1'b0, OFS_CTRL, 8'hBF);
        rd(OFS_CTRL, 1'b0, 16'h00A7);
        cmd(1'b1, 1'b0, OFS_CSR, 8'h18);
        trig();
        rd(OFS_CSR, 1'b0, 16'h00B8);
        rd(5'h00, 1'b0, res(sv[0]));
        // standby wipes both registers and stops the scan
        @(negedge ref_clk);
        standby = 1'b1;
        @(negedge ref_clk);
        standby = 1'b0;
        rd(OFS_CSR, 1'b0, 16'h0000);
        rd(OFS_CTRL, 1'b0, 16'h0007);
        trig();
        rd(OFS_CSR, 1'b0, 16'h0000);
        repeat (20) @(negedge ref_clk);
        check("pending", 16'h0000, 16'(exp_q.size()));
        results();
    end
endmodule
`default_nettype wire
